// ---- logic/osr_pkg.sv ----
// Purpose: constants and carriers for the option byte, security gate and reset init block
// Assumes: 20 MHz core clock
// Notes:   none
package osr_pkg;
	localparam logic [14:0] OSR_OPT_ADDR       = 15'h7fff;
	localparam logic [15:0] OSR_OPT_ALIAS      = 16'hffff;
	localparam int          OSR_SECURE_BIT     = 5;
	localparam int          OSR_WDOG_DIS_BIT   = 2;
	localparam int          OSR_HALT_DIS_BIT   = 1;
	localparam int          OSR_FLASH_BOOT_BIT = 0;
	localparam logic [7:0]  OSR_SECURE_FILL    = 8'hff;
	localparam logic [7:0]  OSR_ZERO8          = 8'h00;
	localparam logic [7:0]  OSR_STACK_RESET    = 8'h6f;
	localparam logic [7:0]  OSR_IDLE_CTL_RESET = 8'h40;
	localparam logic [7:0]  OSR_TXE_RESET      = 8'h01;
	localparam logic [7:0]  OSR_PROG_TIM_10MHZ = 8'h31;
	localparam logic [1:0]  OSR_WIN_MAX        = 2'h3;
	localparam logic [15:0] OSR_IDLE_BOR_PRE   = 16'h00f0;
	localparam logic [4:0]  OSR_CKMON_REL      = 5'h10;
	localparam logic [3:0]  OSR_IDLE_DIV       = 4'h9;

	typedef enum logic [1:0] {
		OSR_OP_READ  = 2'b00,
		OSR_OP_WRITE = 2'b01,
		OSR_OP_PAGE  = 2'b10,
		OSR_OP_MASS  = 2'b11
	} osr_op_t;

	typedef enum logic [1:0] {
		OSR_ST_RESET = 2'b00,
		OSR_ST_BOR   = 2'b01,
		OSR_ST_RUN   = 2'b10
	} osr_state_t;

	typedef struct packed {
		logic       req;
		osr_op_t    op;
		logic       user_isp;
		logic [15:0] addr;
		logic [7:0] wdata;
	} osr_flash_req_t;

	typedef struct packed {
		logic [14:0] pc;
		logic [7:0]  processor_status_reg;
		logic [7:0]  main_control_reg;
		logic [7:0]  interrupt_control_reg;
		logic [7:0]  fast_timer_a_ctrl;
		logic [7:0]  fast_timer_b_ctrl;
		logic [7:0]  high_speed_timer_config;
		logic [7:0]  idle_timer_ctrl;
		logic [7:0]  seg;
		logic [7:0]  stack_pointer;
		logic [7:0]  wakeup_enable_reg;
		logic [7:0]  wakeup_edge_reg;
		logic [7:0]  usart_prescaler_reg;
		logic [7:0]  usart_control_reg;
		logic [7:0]  usart_rx_control_reg;
		logic [7:0]  usart_int_control_reg;
		logic [7:0]  selfprog_addr_low_reg;
		logic [7:0]  selfprog_addr_high_reg;
		logic [7:0]  program_timing_reg;
		logic [1:0]  wd_window;
		logic        ckmon_en;
	} osr_init_t;
endpackage

// ---- logic/osr_core.sv ----
// Purpose: option byte decode, flash security gate, reset sequencing and register init values
// Assumes: reset pin and brownout/clock-ok levels are asynchronous to clk
// Notes:   option byte is held by flash; this block sees it as an input
`timescale 1ns/1ns
//
// Contract
// - Lock bit 5 set refuses flash read/write except user self-programming; mass erase allowed.
// - Bit 2 set disables watchdog; clear makes watchdog pin output with pull-up.
// - Bit 1 set forbids deep stop entry; clear allows it.
// - Bit 0 one boots from flash; zero boots from boot ROM.
// - Locked external reads return FF except the option byte.
// - Locked: writes to flash and option byte, and page erase, inhibited.
// - Option byte readable at alias FFFF regardless of protection.
// - Mass erase always accepted; sole way to clear the lock outside user ISP.
// - Reset from low reset pin or brownout event.
// - In reset ports float, port D high, watchdog pin, port G zero/two pull-ups; watchdog pin pull-up here follows bit 2 clear only, off in rst_n reset.
// - Reset clears idle timer control except oscillator-on flag set.
// - Reset loads stack pointer with 06F.
// - Shift reg, pointers, RAM kept; wake-up enable/edge cleared.
// - Reset clears serial prescaler and controls, transmit-empty flag set.
// - Reset clears self-programming address, presets timing for 10 MHz.
// - Watchdog on: window bits max, clock monitor set; both inhibited in reset.
// - Slow clock at reset end drives watchdog pin low until 16-32 idle clocks.
// - Reset pin also ends deep stop mode.
// - Brownout presets idle timer 00F0-00FF; reset held until underflow.
module osr_core
	import osr_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            reset_pin_n,
	input  wire logic            brownout,
	input  wire logic            clk_ok,
	input  wire logic            halt_req,
	input  wire logic [7:0]      config_option_byte,
	input  wire osr_flash_req_t  flash_req,
	input  wire logic [7:0]      flash_rdata,
	output logic                 flash_rd_en,
	output logic                 flash_wr_en,
	output logic                 flash_page_erase,
	output logic                 flash_mass_erase,
	output logic [14:0]          flash_addr,
	output logic [7:0]           flash_wdata,
	output logic [7:0]           ext_rdata,
	output logic                 ext_rvalid,
	output logic                 ext_refused,
	output logic                 core_reset,
	output logic                 boot_from_flash,
	output logic                 halt_allowed,
	output logic                 halt_active,
	output logic                 wdog_enable,
	output logic                 wdog_output_pin_val,
	output logic                 wdog_output_pin_oe,
	output logic                 wdog_output_pin_pu,
	output logic                 port_g_pin_zero_pu,
	output logic                 port_g_pin_two_pu,
	output logic                 port_d_drive_high,
	output logic                 ports_float,
	output osr_init_t            init_values
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [2:0] meta_q;
	logic [2:0] sync_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 3'b100;
			sync_q <= 3'b100;
		end else begin
			meta_q <= {clk_ok, brownout, ~reset_pin_n};
			sync_q <= meta_q;
		end
	end

	logic pin_rst;
	logic bor_evt;
	logic clk_good;
	assign pin_rst  = sync_q[0];
	assign bor_evt  = sync_q[1];
	assign clk_good = sync_q[2];

	// ----------------------------------------------------------------
	// option decode
	// ----------------------------------------------------------------
	logic secure;
	assign secure = config_option_byte[OSR_SECURE_BIT];

	function automatic logic is_opt_addr(input logic [15:0] a);
		return (a == OSR_OPT_ALIAS) || (a[14:0] == OSR_OPT_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// reset sequencer and idle timer
	// ----------------------------------------------------------------
	osr_state_t  state_q;
	osr_state_t  state_d;
	logic [15:0] idle_q;
	logic [3:0]  pre_q;
	logic        idle_tick;

	assign idle_tick = (pre_q == OSR_IDLE_DIV);

	always_comb begin
		state_d = state_q;
		case (state_q)
			OSR_ST_RESET: begin
				if (bor_evt) begin
					state_d = OSR_ST_BOR;
				end else if (!pin_rst) begin
					state_d = OSR_ST_RUN;
				end
			end
			OSR_ST_BOR: begin
				if (pin_rst) begin
					state_d = OSR_ST_RESET;
				end else if (!bor_evt && idle_tick && idle_q == 16'h0000) begin
					state_d = OSR_ST_RUN;
				end
			end
			OSR_ST_RUN: begin
				if (bor_evt) begin
					state_d = OSR_ST_BOR;
				end else if (pin_rst) begin
					state_d = OSR_ST_RESET;
				end
			end
			default: state_d = OSR_ST_RESET;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= OSR_ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q  <= 4'h0;
			idle_q <= OSR_IDLE_BOR_PRE;
		end else begin
			pre_q <= idle_tick ? 4'h0 : pre_q + 4'h1;
			if (bor_evt) begin
				idle_q <= OSR_IDLE_BOR_PRE;
			end else if (idle_tick && idle_q != 16'h0000) begin
				idle_q <= idle_q - 16'h0001;
			end
		end
	end

	logic in_reset;
	assign in_reset = (state_d != OSR_ST_RUN);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_reset <= 1'b1;
		end else begin
			core_reset <= in_reset;
		end
	end

	// ----------------------------------------------------------------
	// option-driven outputs and deep stop
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_from_flash <= 1'b0;
			halt_allowed    <= 1'b0;
			wdog_enable     <= 1'b0;
		end else begin
			boot_from_flash <= config_option_byte[OSR_FLASH_BOOT_BIT];
			halt_allowed    <= ~config_option_byte[OSR_HALT_DIS_BIT];
			wdog_enable     <= ~config_option_byte[OSR_WDOG_DIS_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_active <= 1'b0;
		end else if (pin_rst || in_reset) begin
			halt_active <= 1'b0;
		end else if (halt_req && !config_option_byte[OSR_HALT_DIS_BIT]) begin
			halt_active <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// clock monitor after reset
	// ----------------------------------------------------------------
	logic       ckmon_err_q;
	logic [4:0] ckmon_cnt_q;
	logic       wd_on;
	assign wd_on = ~config_option_byte[OSR_WDOG_DIS_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ckmon_err_q <= 1'b0;
			ckmon_cnt_q <= 5'h00;
		end else if (in_reset) begin
			ckmon_err_q <= 1'b0;
			ckmon_cnt_q <= 5'h00;
		end else if (state_q != OSR_ST_RUN && wd_on && !clk_good) begin
			ckmon_err_q <= 1'b1;
		end else if (ckmon_err_q && clk_good && idle_tick) begin
			ckmon_cnt_q <= ckmon_cnt_q + 5'h01;
			if (ckmon_cnt_q + 5'h01 == OSR_CKMON_REL) begin
				ckmon_err_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin states
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ports_float        <= 1'b1;
			port_d_drive_high  <= 1'b1;
			port_g_pin_zero_pu <= 1'b1;
			port_g_pin_two_pu  <= 1'b1;
			wdog_output_pin_val <= 1'b1;
			wdog_output_pin_oe <= 1'b0;
			wdog_output_pin_pu <= 1'b0;
		end else begin
			ports_float        <= in_reset;
			port_d_drive_high  <= in_reset;
			port_g_pin_zero_pu <= in_reset;
			port_g_pin_two_pu  <= in_reset;
			wdog_output_pin_val <= ~ckmon_err_q;
			wdog_output_pin_oe <= wd_on & ckmon_err_q;
			wdog_output_pin_pu <= wd_on;
		end
	end

	// ----------------------------------------------------------------
	// initial register values
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_values <= '0;
		end else begin
			init_values.pc                      <= 15'h0000;
			init_values.processor_status_reg    <= OSR_ZERO8;
			init_values.main_control_reg        <= OSR_ZERO8;
			init_values.interrupt_control_reg   <= OSR_ZERO8;
			init_values.fast_timer_a_ctrl       <= OSR_ZERO8;
			init_values.fast_timer_b_ctrl       <= OSR_ZERO8;
			init_values.high_speed_timer_config <= OSR_ZERO8;
			init_values.seg                     <= OSR_ZERO8;
			init_values.idle_timer_ctrl         <= OSR_IDLE_CTL_RESET;
			init_values.stack_pointer           <= OSR_STACK_RESET;
			init_values.wakeup_enable_reg       <= OSR_ZERO8;
			init_values.wakeup_edge_reg         <= OSR_ZERO8;
			init_values.usart_prescaler_reg     <= OSR_ZERO8;
			init_values.usart_control_reg       <= OSR_TXE_RESET;
			init_values.usart_rx_control_reg    <= OSR_ZERO8;
			init_values.usart_int_control_reg   <= OSR_ZERO8;
			init_values.selfprog_addr_low_reg   <= OSR_ZERO8;
			init_values.selfprog_addr_high_reg  <= OSR_ZERO8;
			init_values.program_timing_reg      <= OSR_PROG_TIM_10MHZ;
			init_values.wd_window               <= wd_on ? OSR_WIN_MAX : 2'h0;
			init_values.ckmon_en                <= wd_on;
		end
	end

	// ----------------------------------------------------------------
	// flash access gate
	// ----------------------------------------------------------------
	logic locked;
	logic opt_hit;
	assign locked  = secure & ~flash_req.user_isp;
	assign opt_hit = is_opt_addr(flash_req.addr);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_rd_en      <= 1'b0;
			flash_wr_en      <= 1'b0;
			flash_page_erase <= 1'b0;
			flash_mass_erase <= 1'b0;
			flash_addr       <= 15'h0000;
			flash_wdata      <= OSR_ZERO8;
			ext_refused      <= 1'b0;
		end else begin
			flash_rd_en      <= 1'b0;
			flash_wr_en      <= 1'b0;
			flash_page_erase <= 1'b0;
			flash_mass_erase <= 1'b0;
			ext_refused      <= 1'b0;
			flash_addr       <= flash_req.addr[14:0];
			flash_wdata      <= flash_req.wdata;
			if (flash_req.req && !in_reset) begin
				case (flash_req.op)
					OSR_OP_READ:  flash_rd_en <= 1'b1;
					OSR_OP_WRITE: begin
						flash_wr_en <= ~locked;
						ext_refused <= locked;
					end
					OSR_OP_PAGE:  begin
						flash_page_erase <= ~locked;
						ext_refused      <= locked;
					end
					OSR_OP_MASS:  flash_mass_erase <= 1'b1;
					default:      ext_refused <= 1'b1;
				endcase
			end
		end
	end

	logic rd_pend_q;
	logic rd_mask_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_q <= 1'b0;
			rd_mask_q <= 1'b0;
		end else begin
			rd_pend_q <= flash_req.req && !in_reset && flash_req.op == OSR_OP_READ;
			rd_mask_q <= locked && !opt_hit;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_rvalid <= 1'b0;
			ext_rdata  <= OSR_ZERO8;
		end else begin
			ext_rvalid <= rd_pend_q;
			ext_rdata  <= rd_mask_q ? OSR_SECURE_FILL : flash_rdata;
		end
	end

endmodule

// ---- verification/osr_properties.sv ----
// Purpose: port-level properties of the option, security and reset block
// Assumes: one clock, rst_n async active low
// Notes:   bound to osr_core
`timescale 1ns/1ns
module osr_properties
	import osr_pkg::*;
(
	input wire logic           clk,
	input wire logic           rst_n,
	input wire logic [7:0]     config_option_byte,
	input wire osr_flash_req_t flash_req,
	input wire logic           flash_wr_en,
	input wire logic           flash_mass_erase,
	input wire logic [7:0]     ext_rdata,
	input wire logic           ext_rvalid,
	input wire logic           ext_refused,
	input wire logic           core_reset,
	input wire logic           boot_from_flash,
	input wire logic           halt_allowed,
	input wire logic           halt_active,
	input wire logic           wdog_enable,
	input wire logic           ports_float,
	input wire logic           port_d_drive_high
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_READ: assert property (flash_req.req && flash_req.op == OSR_OP_READ && !core_reset |-> ##2 ext_rvalid)
		else $error("read answer late");
	AST_FILL: assert property (ext_rvalid && config_option_byte[OSR_SECURE_BIT]
		&& $past(flash_req.addr[14:0], 2) != OSR_OPT_ADDR && !$past(flash_req.user_isp, 2)
		|-> ext_rdata == OSR_SECURE_FILL)
		else $error("locked read leaked data");
	AST_ALIAS: assert property (ext_rvalid && $past(flash_req.addr, 2) == OSR_OPT_ALIAS
		|-> ext_rdata == config_option_byte)
		else $error("alias read wrong");
	AST_REFUSE: assert property (flash_req.req && flash_req.op inside {OSR_OP_WRITE, OSR_OP_PAGE} && !core_reset
		&& config_option_byte[OSR_SECURE_BIT] && !flash_req.user_isp |=> ext_refused && !flash_wr_en)
		else $error("locked write not refused");
	AST_MASS: assert property (flash_req.req && flash_req.op == OSR_OP_MASS && !core_reset |=> flash_mass_erase)
		else $error("mass erase dropped");
	AST_DECODE: assert property ($fell(core_reset) |-> ##2 boot_from_flash == config_option_byte[OSR_FLASH_BOOT_BIT]
		&& wdog_enable == !config_option_byte[OSR_WDOG_DIS_BIT])
		else $error("option decode wrong");
	AST_PORTS: assert property (core_reset && $past(core_reset) |-> ports_float && port_d_drive_high)
		else $error("ports not in reset state");
	AST_HALT: assert property ($rose(halt_active) |-> halt_allowed)
		else $error("deep stop entered while forbidden");
endmodule
bind osr_core osr_properties u_props (.clk, .rst_n, .config_option_byte, .flash_req, .flash_wr_en,
	.flash_mass_erase, .ext_rdata, .ext_rvalid, .ext_refused, .core_reset, .boot_from_flash,
	.halt_allowed, .halt_active, .wdog_enable, .ports_float, .port_d_drive_high);

// ---- verification/osr_flash_model.sv ----
// Purpose: flash array beside the option and security block
// Assumes: data valid in the strobe cycle and the one after
// Notes:   undriven data line shows the inverse
`timescale 1ns/1ns
module osr_flash_model
	import osr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        flash_rd_en,
	input  wire logic [14:0] flash_addr,
	input  wire logic [7:0]  opt_byte,
	output logic      [7:0]  flash_rdata
);
	logic        hold_q;
	logic [14:0] addr_q;
	logic [14:0] a;
	logic [7:0]  d;
	always_ff @(posedge clk) begin
		hold_q <= flash_rd_en;
		if (flash_rd_en) begin
			addr_q <= flash_addr;
		end
	end
	assign a = flash_rd_en ? flash_addr : addr_q;
	// option byte kept whole in the top slot
	assign d = (a == OSR_OPT_ADDR) ? opt_byte : a[7:0] ^ {1'b0, a[14:8]};
	assign flash_rdata = (flash_rd_en || hold_q) ? d : ~d;
endmodule

// ---- verification/tb_option_security_reset_init.sv ----
// Purpose: self-checking bench for osr_core
// Assumes: 50 ns clock
// Notes:   results queued by drivers, checked by monitor
`timescale 1ns/1ns
module tb_option_security_reset_init;
	import osr_pkg::*;
	localparam int W = 170;
	typedef struct packed {
		logic [2:0] kind;
		logic [7:0] data;
	} osr_exp_t;
	logic           clk, rst_n, reset_pin_n, brownout, clk_ok, halt_req;
	logic [7:0]     config_option_byte, flash_rdata, flash_wdata, ext_rdata;
	osr_flash_req_t flash_req;
	logic           flash_rd_en, flash_wr_en, flash_page_erase, flash_mass_erase, ext_rvalid, ext_refused;
	logic           core_reset, boot_from_flash, halt_allowed, halt_active, wdog_enable;
	logic           wdog_output_pin_val, wdog_output_pin_oe, wdog_output_pin_pu;
	logic           port_g_pin_zero_pu, port_g_pin_two_pu, port_d_drive_high, ports_float;
	logic [14:0]    flash_addr;
	osr_init_t      init_values;
	osr_exp_t       q[$];
	logic [31:0]    seed;
	int             num_errors, n_checks, cycles, last_wait;
	osr_core uut (.clk, .rst_n, .reset_pin_n, .brownout, .clk_ok, .halt_req, .config_option_byte, .flash_req,
		.flash_rdata, .flash_rd_en, .flash_wr_en, .flash_page_erase, .flash_mass_erase, .flash_addr, .flash_wdata,
		.ext_rdata, .ext_rvalid, .ext_refused, .core_reset, .boot_from_flash, .halt_allowed, .halt_active,
		.wdog_enable, .wdog_output_pin_val, .wdog_output_pin_oe, .wdog_output_pin_pu, .port_g_pin_zero_pu,
		.port_g_pin_two_pu, .port_d_drive_high, .ports_float, .init_values);
	osr_flash_model u_flash (.clk, .flash_rd_en, .flash_addr, .opt_byte(config_option_byte), .flash_rdata);
	//--------------------------------
	// helpers
	//--------------------------------
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic complete_run;
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic compare_level(input logic [W-1:0] got, input logic [W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t level got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic compare_result(input osr_exp_t got, input osr_exp_t exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t result got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic wait_release(input int lim);
		last_wait = 0;
		while (core_reset !== 1'b0 && last_wait < lim) begin
			step(1);
			last_wait++;
		end
		compare_level(W'(core_reset), W'(1'b0));
	endtask
	task automatic pin_reset(input logic [7:0] o);
		osr_init_t e;
		config_option_byte = o;
		reset_pin_n = 1'b0;
		step(8);
		compare_level(W'(halt_active), W'(1'b0));
		compare_level(W'({ports_float, port_d_drive_high, port_g_pin_zero_pu, port_g_pin_two_pu}), W'(4'hf));
		e = '0;
		e.idle_timer_ctrl = OSR_IDLE_CTL_RESET;
		e.stack_pointer = OSR_STACK_RESET;
		e.usart_control_reg = OSR_TXE_RESET;
		e.program_timing_reg = OSR_PROG_TIM_10MHZ;
		e.wd_window = o[OSR_WDOG_DIS_BIT] ? 2'h0 : OSR_WIN_MAX;
		e.ckmon_en = !o[OSR_WDOG_DIS_BIT];
		compare_level(W'(init_values), W'(e));
		reset_pin_n = 1'b1;
		wait_release(30);
		step(2);
		compare_level(W'({boot_from_flash, halt_allowed, wdog_enable, wdog_output_pin_pu}),
			W'({o[0], ~o[1], ~o[2], ~o[2]}));
	endtask
	task automatic access(input osr_op_t op, input logic isp, input logic [15:0] a, input logic [7:0] d);
		osr_exp_t e;
		e = '{{1'b0, op}, (op == OSR_OP_WRITE) ? d : 8'h00};
		if (op == OSR_OP_READ)
			e.data = (a[14:0] == OSR_OPT_ADDR) ? config_option_byte : (config_option_byte[OSR_SECURE_BIT] && !isp) ?
				OSR_SECURE_FILL : a[7:0] ^ {1'b0, a[14:8]};
		if (op inside {OSR_OP_WRITE, OSR_OP_PAGE} && config_option_byte[OSR_SECURE_BIT] && !isp)
			e = '{3'd4, 8'h00};
		q.push_back(e);
		step(1);
		flash_req = '{1'b1, op, isp, a, d};
	endtask
	task automatic take(input osr_exp_t g);
		if (q.size() == 0) begin
			num_errors++;
			$display("[FAIL] %0t unexpected flash result", $time);
		end else
			compare_result(g, q.pop_front());
	endtask
	//--------------------------------
	// clock, timeout, monitor, stimulus
	//--------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			complete_run();
		end
	end
	always @(negedge clk) begin
		if (rst_n && ext_rvalid === 1'b1)
			take('{3'd0, ext_rdata});
		if (rst_n && (flash_wr_en | flash_page_erase | flash_mass_erase | ext_refused) === 1'b1)
			take('{flash_wr_en ? 3'd1 : flash_page_erase ? 3'd2 : flash_mass_erase ? 3'd3 : 3'd4,
				flash_wr_en ? flash_wdata : 8'h00});
	end
	initial begin
		rst_n = 1'b0;
		reset_pin_n = 1'b1;
		brownout = 1'b0;
		clk_ok = 1'b1;
		halt_req = 1'b0;
		config_option_byte = 8'h01;
		flash_req = '0;
		seed = 32'h2d8a_7213;
		step(6);
		rst_n = 1'b1;
		wait_release(30);
		for (int i = 0; i < 6; i++) begin
			seed = rnd(seed);
			pin_reset({2'b00, i[0], 2'b00, seed[2:0]});
			for (int k = 0; k < 4; k++) begin
				access(osr_op_t'(k), 1'b0, 16'h0123, seed[15:8]);
				access(OSR_OP_READ, 1'b0, 16'h7fff, 8'h00);
				access(OSR_OP_READ, 1'b0, OSR_OPT_ALIAS, 8'h00);
			end
			access(OSR_OP_WRITE, 1'b1, 16'h0456, seed[23:16]);
			for (int k = 0; k < 12; k++) begin
				seed = rnd(seed);
				access(osr_op_t'(seed[1:0]), seed[2], {1'b0, seed[30:16]}, seed[15:8]);
			end
			step(1);
			flash_req.req = 1'b0;
			step(4);
			compare_level(W'(q.size()), W'(0));
			halt_req = 1'b1;
			step(1);
			halt_req = 1'b0;
			step(3);
			compare_level(W'(halt_active), W'(!config_option_byte[OSR_HALT_DIS_BIT]));
		end
		clk_ok = 1'b0;
		pin_reset(8'h01);
		compare_level(W'({wdog_output_pin_oe, wdog_output_pin_val}), W'(2'b10));
		clk_ok = 1'b1;
		step(100);
		compare_level(W'({wdog_output_pin_oe, wdog_output_pin_val}), W'(2'b10));
		step(400);
		compare_level(W'({wdog_output_pin_oe, wdog_output_pin_val, wdog_output_pin_pu}), W'(3'b011));
		brownout = 1'b1;
		step(10);
		compare_level(W'(core_reset), W'(1'b1));
		brownout = 1'b0;
		wait_release(3000);
		compare_level(W'(last_wait >= int'(OSR_IDLE_BOR_PRE) * (int'(OSR_IDLE_DIV) + 1)
			&& last_wait <= (int'(OSR_IDLE_BOR_PRE) + 16) * (int'(OSR_IDLE_DIV) + 1) + 16), W'(1'b1));
		complete_run();
	end
endmodule
